// ===== rtl/sffp_front.sv
`timescale 1ns/1ns
module sffp_front
  import sffp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        chip_sel_n,
  input  wire logic        host_to_dev_line_i,
  output logic             host_to_dev_line_o,
  output logic             host_to_dev_line_oe,
  input  wire logic        dev_to_host_line_i,
  output logic             dev_to_host_line_o,
  output logic             dev_to_host_line_oe,
  input  wire logic        protect_pin_n_i,
  output logic             protect_pin_n_o,
  output logic             protect_pin_n_oe,
  input  wire logic        pause_pin_n_i,
  output logic             pause_pin_n_o,
  output logic             pause_pin_n_oe,
  input  wire logic        array_busy,
  input  wire logic [7:0]  array_rd_data,
  output logic      [23:0] array_addr,
  output logic             array_go,
  output sffp_op_t         array_op,
  output logic      [7:0]  page_byte,
  output logic             page_byte_valid,
  output logic      [15:0] status_word,
  output logic             deep_down,
  output logic             paused
);

  typedef struct packed {
    logic        cs_prev;
    logic        sclk_prev;
    logic        paused;
    logic        dpd;
    logic        rst_armed;
    logic        drv_on;
    logic        go;
    logic        pbv;
    sffp_phase_t phase;
    sffp_op_t    op;
    logic [7:0]  cmd;
    logic [7:0]  sh8;
    logic [7:0]  out_sh;
    logic [7:0]  pbyte;
    logic [23:0] addr;
    logic [5:0]  cnt;
    logic [2:0]  clk8;
    logic [2:0]  w_in;
    logic [2:0]  w_out;
    logic [3:0]  out_cnt;
    logic [3:0]  drv;
    logic [3:0]  oe;
    logic [1:0]  nbytes;
    logic [15:0] stat;
    logic [15:0] stat_new;
  } sffp_st_t;

  sffp_st_t   q;
  sffp_st_t   d;
  logic [5:0] s;
  logic       sclk_s, cs_s;
  logic [3:0] io_s;
  logic       rise, fall, cs_rise, act, commit, quad;
  logic       hw_prot, hit_lo, hit_hi, none_lo;
  logic [23:0] hi_addr, lo_addr, umask;
  logic [7:0] c;
  logic [7:0] src;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sffp_sync #(.W(6)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({pause_pin_n_i, protect_pin_n_i, dev_to_host_line_i,
                host_to_dev_line_i, chip_sel_n, sclk}),
    .q       (s)
  );

  assign sclk_s = s[0];
  assign cs_s   = s[1];
  assign io_s   = s[5:2];

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  // An erase may name any address inside its unit, so the low end is
  // aligned down; otherwise a unit straddling a bottom region slips by.
  always_comb begin
    unique case (q.cmd)
      C_WIPE_4K:  umask = MSK_4K;
      C_WIPE_32K: umask = MSK_32K;
      C_WIPE_64K: umask = MSK_64K;
      default:    umask = 24'h000000;
    endcase
    hi_addr = q.addr | umask;
    lo_addr = q.addr & ~umask;
  end

  sffp_region u_rgn_lo (
    .rgn  (q.stat[SB_RGN_HI:SB_RGN_LO]),
    .inv  (q.stat[SB_INV]),
    .addr (lo_addr),
    .hit  (hit_lo),
    .none (none_lo)
  );

  sffp_region u_rgn_hi (
    .rgn  (q.stat[SB_RGN_HI:SB_RGN_LO]),
    .inv  (q.stat[SB_INV]),
    .addr (hi_addr),
    .hit  (hit_hi),
    .none ()
  );

  function automatic logic [23:0] shin(logic [23:0] v, logic [2:0] w,
                                       logic [3:0] b);
    unique case (w)
      3'h2:    shin = {v[21:0], b[1:0]};
      3'h4:    shin = {v[19:0], b};
      default: shin = {v[22:0], b[0]};
    endcase
  endfunction : shin

  function automatic logic [3:0] lead(logic [7:0] v, logic [2:0] w);
    unique case (w)
      3'h2:    lead = {2'h0, v[7:6]};
      3'h4:    lead = v[7:4];
      default: lead = {2'h0, v[7], 1'b0};
    endcase
  endfunction : lead

  function automatic logic [3:0] mask(logic [2:0] w);
    unique case (w)
      3'h2:    mask = 4'h3;
      3'h4:    mask = 4'hf;
      default: mask = 4'h2;
    endcase
  endfunction : mask

  // ----------------------------------------------------------------
  // Link and command logic
  // ----------------------------------------------------------------
  always_comb begin
    d            = q;
    d.go         = 1'b0;
    d.pbv        = 1'b0;
    d.cs_prev    = cs_s;
    d.sclk_prev  = sclk_s;
    d.stat[SB_BUSY] = array_busy;
    quad    = q.stat[SB_QUAD];
    hw_prot = !q.stat[SB_LOCK1] && q.stat[SB_LOCK0] && !io_s[2];
    // Edges come from the sampled clock level, so idle level is free.
    rise    = sclk_s && !q.sclk_prev;
    fall    = !sclk_s && q.sclk_prev;
    cs_rise = cs_s && !q.cs_prev;
    act     = !cs_s && !q.paused;
    commit  = cs_rise && !q.paused && q.clk8 == 3'h0 &&
              q.phase != PH_CMD && !array_busy;
    c       = {q.sh8[6:0], io_s[0]};
    src     = (q.cmd == C_STAT_RDL) ? q.stat[7:0] :
              (q.cmd == C_STAT_RDH) ? q.stat[15:8] : array_rd_data;
    // Pause level only moves while the clock is low; else it waits.
    if (!cs_s && !quad && !sclk_s) begin
      d.paused = !io_s[3];
    end
    if (commit) begin
      unique case (q.cmd)
        C_SET_WL: d.stat[SB_WL] = 1'b1;
        C_CLR_WL: d.stat[SB_WL] = 1'b0;
        C_DEEP_DN: d.dpd = 1'b1;
        C_STAT_WR: begin
          if (q.stat[SB_WL] && q.nbytes != 2'h0 && !q.stat[SB_LOCK1]) begin
            // Frozen fields keep their value under hardware protection.
            d.stat = (q.stat & ~(hw_prot ? STAT_WMSK & ~STAT_HMSK
                                         : STAT_WMSK)) |
                     (q.stat_new & (hw_prot ? STAT_WMSK & ~STAT_HMSK
                                            : STAT_WMSK));
            d.go = 1'b1;
            d.op = OP_STAT;
          end
          d.stat[SB_WL] = 1'b0;
          d.stat[SB_BUSY] = array_busy;
        end
        C_PAGE_WR, C_WIPE_4K, C_WIPE_32K, C_WIPE_64K: begin
          if (q.stat[SB_WL] && (q.phase == PH_IN) == (q.cmd == C_PAGE_WR)) begin
            d.go = !hit_lo && !hit_hi;
            d.op = (q.cmd == C_PAGE_WR) ? OP_PAGE :
                   (q.cmd == C_WIPE_4K) ? OP_4K :
                   (q.cmd == C_WIPE_32K) ? OP_32K : OP_64K;
            d.stat[SB_WL] = 1'b0;
          end
        end
        C_WIPE_ALLA, C_WIPE_ALLB: begin
          if (q.stat[SB_WL]) begin
            d.go = none_lo;
            d.op = OP_ALL;
            d.stat[SB_WL] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (cs_s) begin
      // Select high, paused or not, drops the sequence.
      d.phase  = PH_CMD;
      d.cmd    = C_NONE;
      d.cnt    = 6'h00;
      d.clk8   = 3'h0;
      d.paused = 1'b0;
      d.drv_on = 1'b0;
      d.nbytes = 2'h0;
    end else if (act && rise) begin
      d.clk8 = q.clk8 + 3'h1;
      d.cnt  = q.cnt + 6'(q.w_in);
      unique case (q.phase)
        PH_CMD: begin
          d.sh8 = c;
          if (q.cnt == 6'h07) begin
            d.cmd       = c;
            d.cnt       = 6'h00;
            d.w_in      = 3'h1;
            d.w_out     = 3'h1;
            d.out_cnt   = BYTE_BITS;
            d.rst_armed = (c == C_RST_EN);
            d.phase     = PH_SKIP;
            unique case (c)
              C_RD, C_RD_FAST, C_RD_DO, C_PAGE_WR, C_WIPE_4K,
              C_WIPE_32K, C_WIPE_64K: d.phase = PH_ADDR;
              C_RD_DIO: begin
                d.phase = PH_ADDR;
                d.w_in  = 3'h2;
              end
              C_RD_QO, C_RD_QIO: begin
                if (quad) begin
                  d.phase = PH_ADDR;
                  d.w_in  = (c == C_RD_QIO) ? 3'h4 : 3'h1;
                end else begin
                  d.cmd = C_NONE;
                end
              end
              C_STAT_RDL, C_STAT_RDH: d.phase = PH_OUT;
              C_STAT_WR: d.phase = PH_IN;
              C_DEEP_UP: d.dpd = 1'b0;
              C_RST_GO: begin
                if (q.rst_armed) begin
                  d.stat[SB_WL] = 1'b0;
                  d.dpd = 1'b0;
                end
              end
              default: ;
            endcase
            if (c == C_RD_DO || c == C_RD_DIO) begin
              d.w_out = 3'h2;
            end
            if (c == C_RD_QO || c == C_RD_QIO) begin
              d.w_out = 3'h4;
            end
            if (q.dpd && c != C_DEEP_UP && c != C_RST_EN &&
                c != C_RST_GO) begin
              d.phase = PH_SKIP;
              d.cmd   = C_NONE;
              d.dpd   = 1'b1;
            end
          end
        end
        PH_ADDR: begin
          d.addr = shin(q.addr, q.w_in, io_s);
          if (q.cnt + 6'(q.w_in) == ADDR_BITS) begin
            d.cnt = 6'h00;
            unique case (q.cmd)
              C_RD:               d.phase = PH_OUT;
              C_RD_DIO, C_RD_QIO: d.phase = PH_MODE;
              C_PAGE_WR:          d.phase = PH_IN;
              C_RD_FAST, C_RD_DO, C_RD_QO: d.phase = PH_DUMMY;
              default:            d.phase = PH_SKIP;
            endcase
          end
        end
        PH_MODE: begin
          if (q.cnt + 6'(q.w_in) == MODE_BITS) begin
            d.cnt   = 6'h00;
            d.phase = (q.cmd == C_RD_QIO) ? PH_DUMMY : PH_OUT;
          end
        end
        PH_DUMMY: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt + 6'h01 ==
              ((q.cmd == C_RD_QIO) ? DUMMY_QIO : DUMMY_FAST)) begin
            d.phase = PH_OUT;
          end
        end
        PH_IN: begin
          d.sh8 = c;
          if (q.cnt[2:0] == 3'h7) begin
            d.pbyte = c;
            d.pbv   = (q.cmd == C_PAGE_WR);
            if (q.nbytes == 2'h0) begin
              d.stat_new = {q.stat[15:8], c};
            end else if (q.nbytes == 2'h1) begin
              d.stat_new[15:8] = c;
            end
            if (q.nbytes != 2'h2) begin
              d.nbytes = q.nbytes + 2'h1;
            end
          end
        end
        default: ;
      endcase
    end else if (act && fall && q.phase == PH_OUT) begin
      d.drv_on = 1'b1;
      if (q.out_cnt == BYTE_BITS) begin
        d.drv     = lead(src, q.w_out);
        d.out_sh  = src << q.w_out;
        d.out_cnt = 4'(q.w_out);
        if (q.cmd != C_STAT_RDL && q.cmd != C_STAT_RDH) begin
          d.addr = q.addr + 24'h000001;
        end
      end else begin
        d.drv     = lead(q.out_sh, q.w_out);
        d.out_sh  = q.out_sh << q.w_out;
        d.out_cnt = q.out_cnt + 4'(q.w_out);
      end
    end
    // Released while paused; comes back on resume.
    d.oe = (d.phase == PH_OUT && d.drv_on && !d.paused && !cs_s) ?
           mask(d.w_out) : 4'h0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.cs_prev  <= 1'b1;
      q.phase    <= PH_CMD;
      q.op       <= OP_NONE;
      q.stat     <= STAT_RST;
      q.w_in     <= 3'h1;
      q.w_out    <= 3'h1;
      q.out_cnt  <= BYTE_BITS;
    end else begin
      q <= d;
    end
  end

  assign host_to_dev_line_o  = q.drv[0];
  assign host_to_dev_line_oe = q.oe[0];
  assign dev_to_host_line_o  = q.drv[1];
  assign dev_to_host_line_oe = q.oe[1];
  assign protect_pin_n_o     = q.drv[2];
  assign protect_pin_n_oe    = q.oe[2];
  assign pause_pin_n_o       = q.drv[3];
  assign pause_pin_n_oe      = q.oe[3];
  assign array_addr          = q.addr;
  assign array_go            = q.go;
  assign array_op            = q.op;
  assign page_byte           = q.pbyte;
  assign page_byte_valid     = q.pbv;
  assign status_word         = q.stat;
  assign deep_down           = q.dpd;
  assign paused              = q.paused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pause_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    q.paused |-> !dev_to_host_line_oe;
  endproperty
  a_pause_quiet: assert property (p_pause_quiet)
    else $error("output driven while paused");

  property p_pause_start;
    @(posedge sys_clk) disable iff (!rstn)
    (!cs_s && !quad && !io_s[3] && !sclk_s) |=> q.paused;
  endproperty
  a_pause_start: assert property (p_pause_start)
    else $error("pause not entered with clock low");

  property p_pause_hold;
    @(posedge sys_clk) disable iff (!rstn)
    (q.paused && sclk_s && !cs_s) |=> q.paused;
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("pause ended while clock high");

  property p_wl_set;
    @(posedge sys_clk) disable iff (!rstn)
    (commit && q.cmd == C_SET_WL) |=> q.stat[SB_WL];
  endproperty
  a_wl_set: assert property (p_wl_set)
    else $error("write latch not set");

  property p_wl_clr;
    @(posedge sys_clk) disable iff (!rstn)
    (commit && (q.cmd == C_CLR_WL || q.cmd == C_STAT_WR)) |=>
    !q.stat[SB_WL];
  endproperty
  a_wl_clr: assert property (p_wl_clr)
    else $error("write latch not cleared");

  property p_odd_count;
    @(posedge sys_clk) disable iff (!rstn)
    (cs_rise && q.clk8 != 3'h0) |=> !q.go && $stable(q.stat[SB_WL]);
  endproperty
  a_odd_count: assert property (p_odd_count)
    else $error("partial byte command executed");

  property p_prot_drop;
    @(posedge sys_clk) disable iff (!rstn)
    (commit && (hit_lo || hit_hi) && q.cmd != C_STAT_WR &&
     q.cmd != C_WIPE_ALLA && q.cmd != C_WIPE_ALLB) |=> !array_go;
  endproperty
  a_prot_drop: assert property (p_prot_drop)
    else $error("protected area request issued");

  property p_hw_freeze;
    @(posedge sys_clk) disable iff (!rstn)
    (commit && hw_prot) |=> q.stat[8:2] == $past(q.stat[8:2]);
  endproperty
  a_hw_freeze: assert property (p_hw_freeze)
    else $error("protected status bits changed");

  property p_dpd_ignore;
    @(posedge sys_clk) disable iff (!rstn)
    (q.dpd && act && rise && q.phase == PH_CMD && q.cnt == 6'h07 &&
     c != C_DEEP_UP && c != C_RST_EN && c != C_RST_GO) |=>
    q.phase == PH_SKIP && q.dpd;
  endproperty
  a_dpd_ignore: assert property (p_dpd_ignore)
    else $error("command taken in deep power-down");

  property p_quad_gate;
    @(posedge sys_clk) disable iff (!rstn)
    (!quad && act && rise && q.phase == PH_CMD && q.cnt == 6'h07 &&
     (c == C_RD_QO || c == C_RD_QIO)) |=> q.phase == PH_SKIP;
  endproperty
  a_quad_gate: assert property (p_quad_gate)
    else $error("four-lane command taken while disabled");

  property p_drive_on_fall;
    @(posedge sys_clk) disable iff (!rstn)
    $changed(q.drv) |-> $past(fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("lane output changed off a falling edge");

endmodule : sffp_front

// ===== inc/sffp_pkg.sv
package sffp_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] C_SET_WL    = 8'h06;
  localparam logic [7:0] C_CLR_WL    = 8'h04;
  localparam logic [7:0] C_STAT_WR   = 8'h01;
  localparam logic [7:0] C_STAT_RDL  = 8'h05;
  localparam logic [7:0] C_STAT_RDH  = 8'h35;
  localparam logic [7:0] C_RD        = 8'h03;
  localparam logic [7:0] C_RD_FAST   = 8'h0b;
  localparam logic [7:0] C_RD_DO     = 8'h3b;
  localparam logic [7:0] C_RD_QO     = 8'h6b;
  localparam logic [7:0] C_RD_DIO    = 8'hbb;
  localparam logic [7:0] C_RD_QIO    = 8'heb;
  localparam logic [7:0] C_PAGE_WR   = 8'h02;
  localparam logic [7:0] C_WIPE_4K   = 8'h20;
  localparam logic [7:0] C_WIPE_32K  = 8'h52;
  localparam logic [7:0] C_WIPE_64K  = 8'hd8;
  localparam logic [7:0] C_WIPE_ALLA = 8'h60;
  localparam logic [7:0] C_WIPE_ALLB = 8'hc7;
  localparam logic [7:0] C_DEEP_DN   = 8'hb9;
  localparam logic [7:0] C_DEEP_UP   = 8'hab;
  localparam logic [7:0] C_RST_EN    = 8'h66;
  localparam logic [7:0] C_RST_GO    = 8'h99;
  localparam logic [7:0] C_NONE      = 8'h00;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int          SB_BUSY   = 0;
  localparam int          SB_WL     = 1;
  localparam int          SB_RGN_LO = 2;
  localparam int          SB_RGN_HI = 6;
  localparam int          SB_LOCK0  = 7;
  localparam int          SB_LOCK1  = 8;
  localparam int          SB_QUAD   = 9;
  localparam int          SB_INV    = 14;
  localparam logic [15:0] STAT_RST  = 16'h0000;
  localparam logic [15:0] STAT_WMSK = 16'h43fc;
  localparam logic [15:0] STAT_HMSK = 16'h01fc;

  // ----------------------------------------------------------------
  // Sequence lengths and array geometry
  // ----------------------------------------------------------------
  localparam logic [5:0]  ADDR_BITS  = 6'h18;
  localparam logic [5:0]  MODE_BITS  = 6'h08;
  localparam logic [5:0]  DUMMY_FAST = 6'h08;
  localparam logic [5:0]  DUMMY_QIO  = 6'h04;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [23:0] MSK_4K     = 24'h000fff;
  localparam logic [23:0] MSK_32K    = 24'h007fff;
  localparam logic [23:0] MSK_64K    = 24'h00ffff;
  localparam int          SECT_LSB   = 12;
  localparam int          BLK_LSB    = 16;
  localparam int          ARR_MSB    = 19;
  localparam logic [8:0]  UNITS_SECT = 9'h100;
  localparam logic [8:0]  UNITS_BLK  = 9'h010;

  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_IN, PH_OUT, PH_SKIP
  } sffp_phase_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_PAGE, OP_4K, OP_32K, OP_64K, OP_ALL, OP_STAT
  } sffp_op_t;

endpackage : sffp_pkg

// ===== rtl/sffp_sync.sv
`timescale 1ns/1ns
module sffp_sync
  import sffp_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sffp_sync_t;

  sffp_sync_t r_q;
  sffp_sync_t r_d;

  // The first stage feeds only the second stage.
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule : sffp_sync

// ===== rtl/sffp_region.sv
`timescale 1ns/1ns
module sffp_region
  import sffp_pkg::*;
(
  input  wire logic [4:0]  rgn,
  input  wire logic        inv,
  input  wire logic [23:0] addr,
  output logic             hit,
  output logic             none
);

  logic [2:0] k;
  logic       all;
  logic       empty;
  logic [8:0] idx;
  logic [8:0] tot;
  logic [8:0] cnt;
  logic       span;

  // Small spans count 4KB sectors, large spans count 64KB blocks.
  always_comb begin
    k     = rgn[2] ? 3'h4 : {1'b0, rgn[1:0]};
    all   = (rgn[2:1] == 2'h3) || (rgn[2:0] == 3'h5 && !rgn[4]);
    empty = (rgn[2:0] == 3'h0);
    idx   = rgn[4] ? {1'b0, addr[ARR_MSB:SECT_LSB]}
                   : {5'h00, addr[ARR_MSB:BLK_LSB]};
    tot   = rgn[4] ? UNITS_SECT : UNITS_BLK;
    cnt   = 9'h001 << (k - 3'h1);
    span  = rgn[3] ? (idx < cnt) : (idx >= tot - cnt);
    hit   = (all || (!empty && span)) ^ inv;
    none  = inv ? all : empty;
  end

endmodule : sffp_region

// ===== verification/sffp_host_model.sv
`timescale 1ns/1ns
module sffp_host_model (
  input  wire logic sys_clk,
  input  wire logic io1,
  output logic      sclk,
  output logic      chip_sel_n,
  output logic      io0
);
  logic cpol = 1'b0;
  initial begin
    sclk = 1'b0;
    chip_sel_n = 1'b1;
    io0 = 1'b0;
  end
  // Four system clocks per half period keep the 320 ns serial clock.
  task automatic half(input logic v);
    sclk <= v;
    repeat (4) @(posedge sys_clk);
  endtask : half
  task automatic open_frame();
    half(cpol);
    chip_sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : open_frame
  // A short bit count is how a misaligned frame is made.
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      io0 <= b[i];
      half(1'b0);
      half(1'b1);
    end
  endtask : put
  // Sampled late in the high phase, well after the fall launched it.
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half(1'b0);
      half(1'b1);
      b[i] = io1;
    end
  endtask : get
  task automatic close_frame();
    repeat (4) @(posedge sys_clk);
    sclk <= cpol;
    chip_sel_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask : close_frame
endmodule : sffp_host_model

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import sffp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn, flip, wp_n, hold_n, busy;
  logic [23:0] aa;
  logic        sclk, csn, io0h, o0, e0, o1, e1, o2, e2, o3, e3;
  logic        go, deep, paused;
  logic [15:0] status, gos, n;
  logic [7:0]  b;
  sffp_op_t    op;
  wire         io0 = e0 ? o0 : io0h;
  wire         io1 = e1 ? o1 : flip;
  wire         io2 = e2 ? o2 : wp_n;
  wire         io3 = e3 ? o3 : hold_n;
  int          mismatches, comparisons;
  sffp_front uut (.sys_clk(sys_clk), .rstn(rstn), .sclk(sclk),
    .chip_sel_n(csn), .host_to_dev_line_i(io0), .host_to_dev_line_o(o0),
    .host_to_dev_line_oe(e0), .dev_to_host_line_i(io1),
    .dev_to_host_line_o(o1), .dev_to_host_line_oe(e1),
    .protect_pin_n_i(io2), .protect_pin_n_o(o2), .protect_pin_n_oe(e2),
    .pause_pin_n_i(io3), .pause_pin_n_o(o3), .pause_pin_n_oe(e3),
    .array_busy(busy), .array_rd_data(aa[7:0] ^ 8'h5a), .array_addr(aa),
    .array_go(go), .array_op(op), .page_byte(), .page_byte_valid(),
    .status_word(status), .deep_down(deep), .paused(paused));
  sffp_host_model host (.sys_clk(sys_clk), .io1(io1), .sclk(sclk),
    .chip_sel_n(csn), .io0(io0h));
  always #20 sys_clk = ~sys_clk;
  // The released io1 lane toggles so a stale value can never pass.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      flip <= 1'b0;
      gos  <= 16'h0;
    end else begin
      flip <= ~flip;
      if (go === 1'b1) gos <= gos + 16'h1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [39:0] v, input int nb, input int xb);
    host.open_frame();
    for (int i = 0; i < nb; i++) host.put(v[39-8*i -: 8], 8);
    if (xb > 0) host.put(v[39-8*nb -: 8], xb);
    host.close_frame();
  endtask : frame
  task automatic rd_open(input logic [7:0] cmd, input logic [23:0] a);
    host.open_frame();
    host.put(cmd, 8);
    for (int i = 2; i >= 0; i--) host.put(a[8*i +: 8], 8);
    host.put(8'h00, 8);
  endtask : rd_open
  task automatic getn(input int w, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      host.half(1'b0);
      host.half(1'b1);
      v = (w == 4) ? {v[3:0], io3, io2, io1, io0} : {v[5:0], io1, io0};
    end
  endtask : getn
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    busy = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(status, STAT_RST);
    frame({C_SET_WL, 32'h0}, 1, 0);
    chk(status, 16'h0002);
    frame({C_CLR_WL, 32'h0}, 1, 0);
    chk(status, 16'h0000);
    frame({C_SET_WL, 32'h0}, 1, 1);
    chk(status, 16'h0000);
    host.cpol = 1'b1;
    frame({C_SET_WL, 32'h0}, 1, 0);
    host.open_frame();
    host.put(C_STAT_RDL, 8);
    host.get(b);
    host.close_frame();
    chk({8'h0, b}, 16'h0002);
    host.cpol = 1'b0;
    for (int k = 0; k < 2; k++) begin
      frame({C_SET_WL, 32'h0}, 1, 0);
      frame({C_STAT_WR, 8'h04, k ? 8'h40 : 8'h00, 16'h0}, 3, 0);
      for (int j = 0; j < 2; j++) begin
        frame({C_SET_WL, 32'h0}, 1, 0);
        n = gos;
        frame({C_PAGE_WR, j ? 24'h0f0000 : 24'h000000, 8'h5a}, 5, 0);
        chk(gos - n, {15'h0, j == k});
        chk(status, k ? 16'h4004 : 16'h0004);
      end
    end
    frame({C_SET_WL, 32'h0}, 1, 0);
    frame({C_STAT_WR, 8'h80, 16'h0, 8'h0}, 3, 0);
    wp_n <= 1'b0;
    frame({C_SET_WL, 32'h0}, 1, 0);
    frame({C_STAT_WR, 8'h84, 16'h0, 8'h0}, 3, 0);
    chk(status & STAT_HMSK, 16'h0080);
    wp_n <= 1'b1;
    frame({C_SET_WL, 32'h0}, 1, 0);
    frame({C_STAT_WR, 8'h70, 24'h0}, 2, 0);
    for (int j = 0; j < 2; j++) begin
      frame({C_SET_WL, 32'h0}, 1, 0);
      n = gos;
      frame({j ? C_WIPE_4K : C_WIPE_64K, 24'h00c000, 8'h0}, 4, 0);
      chk(gos - n, {15'h0, j == 1});
    end
    busy <= 1'b1;
    host.open_frame();
    host.put(C_STAT_RDL, 8);
    host.half(1'b0);
    host.half(1'b1);
    hold_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({14'h0, paused, e1}, 16'h0001);
    host.half(1'b0);
    repeat (4) @(posedge sys_clk);
    chk({13'h0, status[SB_BUSY], paused, e1}, 16'h0006);
    host.half(1'b1);
    hold_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({14'h0, paused, e1}, 16'h0002);
    busy <= 1'b0;
    host.half(1'b0);
    repeat (4) @(posedge sys_clk);
    chk({14'h0, paused, e1}, 16'h0001);
    hold_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({15'h0, paused}, 16'h1);
    host.close_frame();
    chk({15'h0, paused}, 16'h0);
    hold_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    frame({C_SET_WL, 32'h0}, 1, 0);
    chk({15'h0, status[SB_WL]}, 16'h1);
    frame({C_RST_EN, 32'h0}, 1, 0);
    frame({C_RST_GO, 32'h0}, 1, 0);
    chk({15'h0, status[SB_WL]}, 16'h0);
    frame({C_DEEP_DN, 32'h0}, 1, 0);
    frame({C_SET_WL, 32'h0}, 1, 0);
    chk({14'h0, deep, status[SB_WL]}, 16'h0002);
    frame({C_DEEP_UP, 32'h0}, 1, 0);
    chk({15'h0, deep}, 16'h0);
    rd_open(C_RD_DO, 24'h000123);
    getn(2, b);
    chk({8'h0, b}, 16'h0079);
    getn(2, b);
    chk({8'h0, b}, 16'h007e);
    host.close_frame();
    rd_open(C_RD_QO, 24'h000123);
    getn(4, b);
    chk({12'h0, e3, e2, e1, e0}, 16'h0000);
    host.close_frame();
    frame({C_SET_WL, 32'h0}, 1, 0);
    frame({C_STAT_WR, 16'h0002, 16'h0}, 3, 0);
    rd_open(C_RD_QO, 24'h0abcde);
    getn(4, b);
    chk({8'h0, b}, 16'h0084);
    host.close_frame();
    print_verdict();
  end
endmodule : tb_top
